// File: hw/scg_cfg.svh
// constants for the source channel gpio logic: times, counts, reset values
// assumes a single 40 MHz system clock and a synchronous active-low reset
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

// ==========================================================
// clock and timing
`define SCG_CLK_HZ       40000000
`define SCG_PULSE_MS     100
`define SCG_DEB_US       5000
`define SCG_PULSE_CYCLES ((`SCG_CLK_HZ / 1000) * `SCG_PULSE_MS)
`define SCG_DEB_CYCLES   ((`SCG_CLK_HZ / 1000000) * `SCG_DEB_US)

// ==========================================================
// command line positions (pins 11 to 15)
`define SCG_LINE_ON      0
`define SCG_LINE_OFF     1
`define SCG_LINE_3       2
`define SCG_LINE_4       3
`define SCG_LINE_5       4
`define SCG_NUM_LINES    5

// ==========================================================
// profile encoding and reset values
`define SCG_PROF_HYBRID  1'b1
`define SCG_PIN_IDLE     1'b1
`define SCG_LAMP_RST     5'h00
`define SCG_ROUTE_RST    3'h0

`endif

// File: hw/scg_pkg.sv
// types shared by the source channel gpio logic
// assumes scg_cfg.svh is on the include path
package scg_pkg;

  // ==========================================================
  // channel state, gray along off to on
  typedef enum logic [0:0]
  {
    SCG_OFF = 1'b0,
    SCG_ON  = 1'b1
  } scg_chan_t;

  // ==========================================================
  // lamp and pulse outputs, bit 0 is output line one
  typedef struct packed
  {
    logic aux5;    // codec: talk to source, hybrid: stop pulse
    logic aux4;    // codec: mute, hybrid: start pulse
    logic aux3;    // codec: talk to control room, hybrid: preview
    logic offLamp;
    logic onLamp;
  } scg_lamp_t;

  // ==========================================================
  // state handed to the console audio path
  typedef struct packed
  {
    logic talkToSource;
    logic previewRoute;
    logic silence;
  } scg_route_t;

endpackage

// File: hw/scg_input_cond.sv
// one active-low command line: two-flop synchroniser, debounce, assert event
// assumes pin_b is asynchronous to clk and idles high
`include "scg_cfg.svh"

module scg_input_cond
  import scg_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = `SCG_DEB_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_b,
  output logic      level,
  output logic      assertEv
);

  localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DEB_CYCLES - 1);

  logic          sync1;
  logic          sync2;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_level;
  logic          next_assertEv;
  logic          raw;

  // ==========================================================
  // debounce: the line must hold a new level for the full count
  always_comb
  begin
    raw           = ~sync2;
    next_cnt      = '0;
    next_level    = level;
    next_assertEv = 1'b0;
    if (raw != level)
    begin
      if (cnt == LAST)
      begin
        next_level    = raw;
        next_assertEv = raw;
      end
      else
      begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // ==========================================================
  // registers; sync1 feeds only sync2
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sync1    <= `SCG_PIN_IDLE;
      sync2    <= `SCG_PIN_IDLE;
      cnt      <= '0;
      level    <= 1'b0;
      assertEv <= 1'b0;
    end
    else
    begin
      sync1    <= pin_b;
      sync2    <= sync1;
      cnt      <= next_cnt;
      level    <= next_level;
      assertEv <= next_assertEv;
    end
  end

endmodule

// File: hw/scg_channel.sv
// one console channel's gpio logic towards a codec or a telephone hybrid
// assumes command pins and the profile strap are asynchronous pins
//
// Behaviour
// - codec talk-to-room silences, routes source to preview
// - codec talk-to-source input acts like button
// - codec on lamp: on, no talk-to-room, no mute
// - codec off lamp whenever channel off
// - codec talk-to-room lamp while that talk active
// - codec mute silences outputs, lights mute lamp
// - codec talk-to-source lamp while function active
// - hybrid reset turns off without stop pulse
// - hybrid ready input lights the off lamp while channel off
// - hybrid on lamp whenever channel is on
// - hybrid preview command sets preview, lights lamp
// - hybrid 100 ms start on turn-on or preview
// - hybrid 100 ms stop on off command
`include "scg_cfg.svh"

module scg_channel
  import scg_pkg::*;
#(
  parameter int unsigned CLK_HZ       = `SCG_CLK_HZ,
  parameter int unsigned PULSE_CYCLES = (CLK_HZ / 1000) * `SCG_PULSE_MS,
  parameter int unsigned DEB_CYCLES   = `SCG_DEB_CYCLES
)
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [`SCG_NUM_LINES-1:0] cmdIn_b,
  input  wire logic                      profileSel,
  output scg_lamp_t                      lampOut,
  output scg_route_t                     routeOut
);

  localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);
  localparam logic [PW-1:0] LAST = PW'(PULSE_CYCLES - 1);

  logic [`SCG_NUM_LINES-1:0] lvl;
  logic [`SCG_NUM_LINES-1:0] ev;
  logic                      profS1;
  logic                      profS2;
  logic                      isHyb;
  scg_chan_t                 chanState;
  scg_chan_t                 next_chanState;
  logic                      preview;
  logic                      next_preview;
  logic [1:0]                pulseAct;
  logic [1:0]                next_pulseAct;
  logic [PW-1:0]             pulseCnt [2];
  logic [PW-1:0]             next_pulseCnt [2];
  logic [1:0]                trig;
  scg_lamp_t                 next_lampOut;
  scg_route_t                next_routeOut;
  logic                      chanOn;
  logic                      offEv;
  logic                      hybRstEv;
  logic                      talkCr;
  logic                      mute;
  logic                      talkSrc;
  logic                      ready;

  // ==========================================================
  // input conditioning, one per command line
  generate
    for (genvar i = 0; i < `SCG_NUM_LINES; i++)
    begin : g_line
      scg_input_cond #(
        .DEB_CYCLES (DEB_CYCLES)
      ) u_cond (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin_b    (cmdIn_b[i]),
        .level    (lvl[i]),
        .assertEv (ev[i])
      );
    end
  endgenerate

  // ==========================================================
  // profile decode; lines three to five change meaning with it
  always_comb
  begin
    isHyb    = (profS2 == `SCG_PROF_HYBRID);
    chanOn   = (chanState == SCG_ON);
    offEv    = ev[`SCG_LINE_OFF];
    hybRstEv = isHyb & ev[`SCG_LINE_4];
    talkCr   = ~isHyb & lvl[`SCG_LINE_3];
    mute     = ~isHyb & lvl[`SCG_LINE_4];
    talkSrc  = ~isHyb & lvl[`SCG_LINE_5];
    ready    = isHyb & lvl[`SCG_LINE_5];
  end

  // ==========================================================
  // channel state and preview; off and reset win over on
  always_comb
  begin
    next_chanState = chanState;
    if (offEv || hybRstEv)
    begin
      next_chanState = SCG_OFF;
    end
    else if (ev[`SCG_LINE_ON])
    begin
      next_chanState = SCG_ON;
    end
    next_preview = preview;
    if (!isHyb || offEv || hybRstEv)
    begin
      next_preview = 1'b0;
    end
    else if (ev[`SCG_LINE_3])
    begin
      next_preview = 1'b1;
    end
  end

  // ==========================================================
  // start and stop pulse triggers, hybrid profile only
  always_comb
  begin
    trig[0] = isHyb & ((~chanOn & (next_chanState == SCG_ON))
                       | (next_preview & ~preview));
    trig[1] = isHyb & chanOn & offEv;
  end

  // ==========================================================
  // pulse timers; a trigger while running is ignored
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_pulseAct[i] = pulseAct[i];
      next_pulseCnt[i] = pulseCnt[i];
      if (pulseAct[i])
      begin
        if (pulseCnt[i] == LAST)
        begin
          next_pulseAct[i] = 1'b0;
          next_pulseCnt[i] = '0;
        end
        else
        begin
          next_pulseCnt[i] = pulseCnt[i] + PW'(1);
        end
      end
      else if (trig[i])
      begin
        next_pulseAct[i] = 1'b1;
        next_pulseCnt[i] = '0;
      end
    end
  end

  // ==========================================================
  // lamp and route outputs per profile
  always_comb
  begin
    if (isHyb)
    begin
      next_lampOut.onLamp  = chanOn;
      next_lampOut.offLamp = ~chanOn & ready;
      next_lampOut.aux3    = preview;
      next_lampOut.aux4    = pulseAct[0];
      next_lampOut.aux5    = pulseAct[1];
    end
    else
    begin
      next_lampOut.onLamp  = chanOn & ~talkCr & ~mute;
      next_lampOut.offLamp = ~chanOn;
      next_lampOut.aux3    = talkCr;
      next_lampOut.aux4    = mute;
      next_lampOut.aux5    = talkSrc;
    end
    next_routeOut.silence      = talkCr | mute;
    next_routeOut.previewRoute = talkCr;
    next_routeOut.talkToSource = talkSrc;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      profS1      <= 1'b0;
      profS2      <= 1'b0;
      chanState   <= SCG_OFF;
      preview     <= 1'b0;
      pulseAct    <= 2'h0;
      pulseCnt[0] <= '0;
      pulseCnt[1] <= '0;
      lampOut     <= `SCG_LAMP_RST;
      routeOut    <= `SCG_ROUTE_RST;
    end
    else
    begin
      profS1      <= profileSel;
      profS2      <= profS1;
      chanState   <= next_chanState;
      preview     <= next_preview;
      pulseAct    <= next_pulseAct;
      pulseCnt[0] <= next_pulseCnt[0];
      pulseCnt[1] <= next_pulseCnt[1];
      lampOut     <= next_lampOut;
      routeOut    <= next_routeOut;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_onCmd;
    ev[`SCG_LINE_ON] && !offEv && !hybRstEv |=> chanState == SCG_ON;
  endproperty
  a_onCmd: assert property (p_onCmd)
    else $error("on command did not turn channel on");

  property p_offCmd;
    offEv |=> chanState == SCG_OFF;
  endproperty
  a_offCmd: assert property (p_offCmd)
    else $error("off command did not turn channel off");

  property p_profile;
    $past(rst_b) && $past(isHyb) |-> lampOut.aux3 == $past(preview);
  endproperty
  a_profile: assert property (p_profile)
    else $error("line three output ignores profile");

  property p_talkCr;
    $past(rst_b) && $past(!isHyb && lvl[`SCG_LINE_3])
      |-> routeOut.silence && routeOut.previewRoute && lampOut.aux3;
  endproperty
  a_talkCr: assert property (p_talkCr)
    else $error("talk to control room not applied");

  property p_talkSrc;
    $past(rst_b) && $past(!isHyb)
      |-> lampOut.aux5 == $past(lvl[`SCG_LINE_5])
          && routeOut.talkToSource == lampOut.aux5;
  endproperty
  a_talkSrc: assert property (p_talkSrc)
    else $error("talk to source lamp mismatch");

  property p_codecOn;
    $past(rst_b) && $past(!isHyb)
      |-> lampOut.onLamp == $past(chanOn && !lvl[`SCG_LINE_3] && !lvl[`SCG_LINE_4]);
  endproperty
  a_codecOn: assert property (p_codecOn)
    else $error("codec on lamp mismatch");

  property p_codecOff;
    $past(rst_b) && $past(!isHyb) |-> lampOut.offLamp == $past(!chanOn);
  endproperty
  a_codecOff: assert property (p_codecOff)
    else $error("codec off lamp mismatch");

  property p_mute;
    $past(rst_b) && $past(!isHyb && lvl[`SCG_LINE_4])
      |-> routeOut.silence && lampOut.aux4 && !lampOut.onLamp;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute not applied");

  property p_hybReset;
    hybRstEv && !offEv && !pulseAct[1] |=> chanState == SCG_OFF && !pulseAct[1];
  endproperty
  a_hybReset: assert property (p_hybReset)
    else $error("reset command sent a stop pulse");

  property p_ready;
    $past(rst_b) && $past(isHyb)
      |-> lampOut.offLamp == $past(!chanOn && lvl[`SCG_LINE_5]);
  endproperty
  a_ready: assert property (p_ready)
    else $error("hybrid off lamp mismatch");

  property p_hybOn;
    $past(rst_b) && $past(isHyb) |-> lampOut.onLamp == $past(chanOn);
  endproperty
  a_hybOn: assert property (p_hybOn)
    else $error("hybrid on lamp mismatch");

  property p_preview;
    isHyb && ev[`SCG_LINE_3] && !offEv && !hybRstEv |=> preview ##1 lampOut.aux3;
  endproperty
  a_preview: assert property (p_preview)
    else $error("preview command not applied");

  property p_start;
    trig[0] && !pulseAct[0] |=> pulseAct[0] && pulseCnt[0] == '0 ##1 lampOut.aux4;
  endproperty
  a_start: assert property (p_start)
    else $error("start pulse not launched");

  property p_stop;
    isHyb && chanOn && offEv && !pulseAct[1] |=> pulseAct[1] ##1 lampOut.aux5;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop pulse not launched");

  property p_pulseLen;
    $fell(pulseAct[0]) |-> $past(pulseCnt[0]) == LAST;
  endproperty
  a_pulseLen: assert property (p_pulseLen)
    else $error("start pulse length wrong");

  property p_noRestart;
    pulseAct[1] && trig[1] && pulseCnt[1] != LAST
      |=> pulseAct[1] && pulseCnt[1] == $past(pulseCnt[1]) + PW'(1);
  endproperty
  a_noRestart: assert property (p_noRestart)
    else $error("running pulse restarted");

  property p_noRestartStart;
    pulseAct[0] && trig[0] && pulseCnt[0] != LAST
      |=> pulseAct[0] && pulseCnt[0] == $past(pulseCnt[0]) + PW'(1);
  endproperty
  a_noRestartStart: assert property (p_noRestartStart)
    else $error("running start pulse restarted");

endmodule

// File: tb/scg_source_model.sv
// behavioural source device: the codec or hybrid control contacts
// assumes the bench calls its tasks; open contacts are pulled high
module scg_source_model
(
  input  wire logic       clk,
  output logic      [4:0] cmdIn_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // contacts, all open until the bench closes one
  initial cmdIn_b = 5'h1f;

  // close a contact on the falling edge, half a cycle after the sampling edge
  task automatic press(input int line);
    @(negedge clk);
    cmdIn_b[line] = 1'b0;
  endtask

  // open a contact; the pull-up takes the line back high
  task automatic lift(input int line);
    @(negedge clk);
    cmdIn_b[line] = 1'b1;
  endtask

  // bounce shorter than the debounce time
  task automatic bounce(input int line, input int len);
    press(line);
    repeat (len) @(negedge clk);
    lift(line);
  endtask
endmodule

// File: tb/scg_channel_test.sv
// self-checking bench for one channel in codec and hybrid profiles
// assumes short debounce and pulse counts so the run stays brief
module scg_channel_test
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // shortened counts and signals
  localparam int unsigned DEB    = 4;
  localparam int unsigned PUL    = 20;
  localparam int unsigned SETTLE = DEB + 8;
  localparam int unsigned LIMIT  = 3000;

  logic       clk;
  logic       rst_b;
  logic       profileSel;
  logic [4:0] cmdIn_b;
  logic [4:0] lampVec;
  scg_lamp_t  lampOut;
  scg_route_t routeOut;
  int         errCount;
  int         samplesChecked;
  int         cycles;
  int         hiCount;

  assign lampVec = lampOut;

  // ==========================================================
  // design and its far side
  scg_channel #(.PULSE_CYCLES(PUL), .DEB_CYCLES(DEB)) uut
  (
    .clk        (clk),
    .rst_b      (rst_b),
    .cmdIn_b    (cmdIn_b),
    .profileSel (profileSel),
    .lampOut    (lampOut),
    .routeOut   (routeOut)
  );

  scg_source_model src
  (
    .clk     (clk),
    .cmdIn_b (cmdIn_b)
  );

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
    samplesChecked++;
    if (seen !== expd)
    begin
      errCount++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic settle();
    repeat (SETTLE) @(negedge clk);
  endtask

  task automatic tap(input int line);
    src.press(line);
    settle();
    src.lift(line);
    settle();
  endtask

  // counts the cycles a lamp or pulse line is high within a window
  task automatic measure(input int idx);
    hiCount = 0;
    repeat (60)
    begin
      @(negedge clk);
      if (lampVec[idx] === 1'b1)
        hiCount++;
    end
  endtask

  task automatic do_reset(input logic prof);
    @(negedge clk);
    rst_b = 1'b0;
    profileSel = prof;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // codec profile scenarios
  task automatic test_codec_basic();
    do_reset(1'b0);
    check({3'h0, lampVec}, 8'h02, "codec reset lamps");
    check({5'h0, routeOut}, 8'h00, "codec reset route");
    tap(0);
    check({3'h0, lampVec}, 8'h01, "codec on lamps");
    src.bounce(1, 2);
    settle();
    check({3'h0, lampVec}, 8'h01, "bounce ignored");
    $display("test codec_basic done");
  endtask

  task automatic test_codec_hold();
    int         lines[3] = '{2, 3, 4};
    logic [7:0] lamps[3] = '{8'h05 & 8'h04, 8'h08, 8'h11};
    logic [7:0] routes[3] = '{8'h03, 8'h01, 8'h04};
    for (int i = 0; i < 3; i++)
    begin
      src.press(lines[i]);
      settle();
      check({3'h0, lampVec}, lamps[i], "held lamps");
      check({5'h0, routeOut}, routes[i], "held route");
      src.lift(lines[i]);
      settle();
      check({3'h0, lampVec}, 8'h01, "released lamps");
    end
    tap(1);
    check({3'h0, lampVec}, 8'h02, "codec off lamps");
    $display("test codec_hold done");
  endtask

  // ==========================================================
  // hybrid profile scenarios
  task automatic test_hybrid_start();
    do_reset(1'b1);
    check({3'h0, lampVec}, 8'h00, "hybrid reset lamps");
    fork
      measure(3);
      begin
        src.press(0);
        repeat (10) @(negedge clk);
        src.press(2);
        settle();
        src.lift(0);
        src.lift(2);
        settle();
      end
    join
    check(hiCount[7:0], PUL[7:0], "start pulse length");
    check({3'h0, lampVec}, 8'h05, "on and preview lamps");
    $display("test hybrid_start done");
  endtask

  task automatic test_hybrid_stop();
    fork
      measure(4);
      tap(1);
    join
    check(hiCount[7:0], PUL[7:0], "stop pulse length");
    check({3'h0, lampVec}, 8'h00, "off lamps");
    src.press(4);
    settle();
    check({3'h0, lampVec}, 8'h02, "ready lamp");
    check({5'h0, routeOut}, 8'h00, "hybrid route idle");
    src.lift(4);
    settle();
    fork
      measure(3);
      tap(2);
    join
    check(hiCount[7:0], PUL[7:0], "preview start pulse");
    check({3'h0, lampVec}, 8'h04, "preview lamp");
    $display("test hybrid_stop done");
  endtask

  task automatic test_hybrid_reset();
    tap(0);
    repeat (PUL) @(negedge clk);
    fork
      measure(4);
      tap(3);
    join
    check(hiCount[7:0], 8'h00, "no stop pulse");
    check({3'h0, lampVec}, 8'h00, "reset lamps");
    $display("test hybrid_reset done");
  endtask

  // off, on and off again while the stop pulse still runs
  task automatic test_hybrid_retrigger();
    tap(0);
    repeat (PUL) @(negedge clk);
    fork
      measure(4);
      begin
        src.press(1);
        src.press(0);
        repeat (5) @(negedge clk);
        src.lift(1);
        repeat (7) @(negedge clk);
        src.press(1);
        settle();
        src.lift(0);
        src.lift(1);
        settle();
      end
    join
    check(hiCount[7:0], PUL[7:0], "stop pulse not restarted");
    check({3'h0, lampVec}, 8'h00, "off after retrigger");
    $display("test hybrid_retrigger done");
  endtask

  // strap changed while running: lines three to five change meaning
  task automatic test_profile_swap();
    @(negedge clk);
    profileSel = 1'b0;
    repeat (4) @(negedge clk);
    check({3'h0, lampVec}, 8'h02, "swapped to codec lamps");
    src.press(4);
    settle();
    check({3'h0, lampVec}, 8'h12, "line five as talk to source");
    check({5'h0, routeOut}, 8'h04, "swapped route");
    src.lift(4);
    settle();
    check({3'h0, lampVec}, 8'h02, "swapped lamps released");
    $display("test profile_swap done");
  endtask

  // ==========================================================
  // cuts a hang short
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clk);
      cycles++;
      if (cycles >= LIMIT)
      begin
        errCount++;
        giveVerdict();
      end
    end
  end

  // main sequence
  initial
  begin
    errCount = 0;
    samplesChecked = 0;
    rst_b = 1'b0;
    profileSel = 1'b0;
    repeat (2) @(negedge clk);
    test_codec_basic();
    test_codec_hold();
    test_hybrid_start();
    test_hybrid_stop();
    test_hybrid_reset();
    test_hybrid_retrigger();
    test_profile_swap();
    giveVerdict();
  end
endmodule
